// >>> clmo_pkg.sv
// constants and types shared by the cache line maintenance unit
package clmo_pkg;
    // line geometry: 32-byte lines
    localparam int LINE_BYTES = 32;
    localparam int LINE_SHIFT = 5;
    localparam int ADDR_W = 32;
    localparam logic [31:0] LINE_INCR = 32'h0000_0020;
    localparam logic [31:0] LINE_MASK = 32'hffff_ffe0;

    // single 16-bit instruction word layout
    localparam int INSN_W = 16;
    localparam int SIG_HI = 15;
    localparam int SIG_LO = 6;
    localparam int POSTINC_BIT = 5;
    localparam int OP_HI = 4;
    localparam int OP_LO = 3;
    localparam int PREG_HI = 2;
    localparam int PREG_LO = 0;
    localparam int PREG_W = 3;
    // arbitrary class signature marking a cache-control word
    localparam logic [9:0] CC_SIGNATURE = 10'h024;

    // operation codes held in the op field
    typedef enum logic [1:0] {
        CLMO_OP_PREFETCH = 2'h0,
        CLMO_OP_WBACK    = 2'h1,
        CLMO_OP_WBINV    = 2'h2,
        CLMO_OP_IINV     = 2'h3
    } clmo_op_e;

    // sequencer states, one-hot
    typedef enum logic [3:0] {
        CLMO_S_IDLE = 4'h1,
        CLMO_S_LOOK = 4'h2,
        CLMO_S_WB   = 4'h4,
        CLMO_S_SPARE = 4'h8
    } clmo_state_e;

    localparam logic [31:0] ADDR_RST = 32'h0000_0000;
endpackage

// >>> clmo_line_ops.sv
// per-line cache maintenance sequencer between core pipeline and next memory level
`timescale 1ns/1ns

// What this block does
// - write-back selects line at pointer address
// - dirty valid line written out, then cleaned
// - clean or missing line: write-back does nothing
// - protection faults silently turn op into nop
// - post-increment adds one line to pointer
// - write-back-invalidate writes dirty line, then invalidates
// - write-back-invalidate miss causes no activity
// - instruction invalidate clears addressed icache line
// - instruction cache never written back
// - ops bundled in parallel are rejected
// - every op is one 16-bit word
// - prefetch fills only absent cacheable lines
// - prefetch idle if present or fill busy
// - line length fixed at 32 bytes
module clmo_line_ops #(
    parameter int PREG_W = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // instruction from core
    input wire logic insn_valid,
    input wire logic [15:0] insn_word,
    input wire logic insn_parallel,
    input wire logic [31:0] ptr_value,
    // pointer write-back, stall and reject to core
    output logic ptr_wr_q,
    output logic [PREG_W-1:0] ptr_wr_idx_q,
    output logic [31:0] ptr_wr_data_q,
    output logic stall_q,
    output logic reject_q,
    // cache lookup and line commands
    output logic lookup_q,
    output logic [31:0] line_addr_q,
    input wire logic dc_hit,
    input wire logic dc_dirty,
    input wire logic prot_fault,
    input wire logic cacheable_attribute,
    input wire logic fill_busy,
    output logic dc_clean_q,
    output logic dc_inval_q,
    output logic ic_inval_q,
    output logic fill_req_q,
    // write-back to next memory level
    output logic wb_req_q,
    input wire logic wb_ready
);
    clmo_pkg::clmo_state_e state_q, state_d;
    logic [1:0] op_q;
    logic postinc_q;
    logic [31:0] ptr_q;

    // decode of the single short instruction word
    wire sig_ok = insn_word[clmo_pkg::SIG_HI:clmo_pkg::SIG_LO] == clmo_pkg::CC_SIGNATURE;
    wire idle = state_q == clmo_pkg::CLMO_S_IDLE;
    wire take = insn_valid && idle && sig_ok && !insn_parallel;
    wire refuse = insn_valid && idle && (insn_parallel || !sig_ok);
    wire [1:0] op_in = insn_word[clmo_pkg::OP_HI:clmo_pkg::OP_LO];
    wire [PREG_W-1:0] preg_in = PREG_W'(insn_word[clmo_pkg::PREG_HI:clmo_pkg::PREG_LO]);
    wire [31:0] line_in = ptr_value & clmo_pkg::LINE_MASK;

    wire look = state_q == clmo_pkg::CLMO_S_LOOK;
    wire in_wb = state_q == clmo_pkg::CLMO_S_WB;
    wire is_pf = op_q == clmo_pkg::CLMO_OP_PREFETCH;
    wire is_wbk = op_q == clmo_pkg::CLMO_OP_WBACK;
    wire is_wbi = op_q == clmo_pkg::CLMO_OP_WBINV;
    wire is_ii = op_q == clmo_pkg::CLMO_OP_IINV;
    // a protection fault makes every op a nop, with no fault raised
    wire live = look && !prot_fault;
    wire need_wb = live && (is_wbk || is_wbi) && dc_hit && dc_dirty;
    wire wb_done = in_wb && wb_ready;
    // op finishes either straight from lookup or once the write-back is taken
    wire fin = (look && !need_wb) || wb_done;

    wire clean_d = wb_done && is_wbk;
    wire dinv_d = (wb_done && is_wbi) || (live && is_wbi && dc_hit && !dc_dirty);
    wire iinv_d = live && is_ii;
    wire fill_d = live && is_pf && !dc_hit && cacheable_attribute && !fill_busy;
    wire [31:0] ptr_next = ptr_q + clmo_pkg::LINE_INCR;

    always_comb begin
        state_d = state_q;
        case (state_q)
            clmo_pkg::CLMO_S_IDLE: begin
                if (take) begin
                    state_d = clmo_pkg::CLMO_S_LOOK;
                end
            end
            clmo_pkg::CLMO_S_LOOK: begin
                state_d = need_wb ? clmo_pkg::CLMO_S_WB : clmo_pkg::CLMO_S_IDLE;
            end
            clmo_pkg::CLMO_S_WB: begin
                if (wb_ready) begin
                    state_d = clmo_pkg::CLMO_S_IDLE;
                end
            end
            default: begin
                state_d = clmo_pkg::CLMO_S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= clmo_pkg::CLMO_S_IDLE;
            stall_q <= 1'b0;
            lookup_q <= 1'b0;
            wb_req_q <= 1'b0;
        end else begin
            state_q <= state_d;
            stall_q <= state_d != clmo_pkg::CLMO_S_IDLE;
            lookup_q <= state_d == clmo_pkg::CLMO_S_LOOK;
            wb_req_q <= state_d == clmo_pkg::CLMO_S_WB;
        end
    end

    // captured operation
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            op_q <= 2'h0;
            postinc_q <= 1'b0;
            ptr_q <= clmo_pkg::ADDR_RST;
            line_addr_q <= clmo_pkg::ADDR_RST;
            ptr_wr_idx_q <= '0;
        end else if (take) begin
            op_q <= op_in;
            postinc_q <= insn_word[clmo_pkg::POSTINC_BIT];
            ptr_q <= ptr_value;
            line_addr_q <= line_in;
            ptr_wr_idx_q <= preg_in;
        end
    end

    // one-cycle command and answer pulses
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dc_clean_q <= 1'b0;
            dc_inval_q <= 1'b0;
            ic_inval_q <= 1'b0;
            fill_req_q <= 1'b0;
            reject_q <= 1'b0;
            ptr_wr_q <= 1'b0;
            ptr_wr_data_q <= clmo_pkg::ADDR_RST;
        end else begin
            dc_clean_q <= clean_d;
            dc_inval_q <= dinv_d;
            ic_inval_q <= iinv_d;
            fill_req_q <= fill_d;
            reject_q <= refuse;
            // pointer update happens even for a nop, since it is register arithmetic
            ptr_wr_q <= fin && postinc_q;
            if (fin && postinc_q) begin
                ptr_wr_data_q <= ptr_next;
            end
        end
    end

    // checks
    a_wb_then_clean: assert property (@(posedge clk) disable iff (rst)
        wb_req_q && wb_ready && is_wbk |=> dc_clean_q && !wb_req_q)
        else $error("dirty write-back did not clean the line");
    a_clean_no_wb: assert property (@(posedge clk) disable iff (rst)
        look && is_wbk && !(dc_hit && dc_dirty) |=> !wb_req_q && !dc_clean_q && !dc_inval_q)
        else $error("write-back of clean or absent line was not a nop");
    a_prot_silent: assert property (@(posedge clk) disable iff (rst)
        look && prot_fault |=> !wb_req_q && !dc_clean_q && !dc_inval_q && !ic_inval_q && !fill_req_q)
        else $error("protection fault did not turn op into nop");
    a_postinc_line: assert property (@(posedge clk) disable iff (rst)
        ptr_wr_q |-> ptr_wr_data_q == $past(ptr_q) + 32'h0000_0020)
        else $error("post-increment was not one line");
    a_wbinv_order: assert property (@(posedge clk) disable iff (rst)
        wb_req_q && wb_ready && is_wbi |=> dc_inval_q && !wb_req_q)
        else $error("invalidate did not follow write-back");
    a_miss_quiet: assert property (@(posedge clk) disable iff (rst)
        look && is_wbi && !dc_hit |=> !wb_req_q && !dc_inval_q && !fill_req_q)
        else $error("write-back-invalidate miss caused activity");
    a_iinv_nowb: assert property (@(posedge clk) disable iff (rst)
        look && is_ii && !prot_fault |=> ic_inval_q && !wb_req_q && !dc_inval_q)
        else $error("instruction invalidate misbehaved");
    a_parallel_refused: assert property (@(posedge clk) disable iff (rst)
        insn_valid && insn_parallel && !stall_q |=> reject_q && !lookup_q)
        else $error("bundled op was accepted");
    a_prefetch_cond: assert property (@(posedge clk) disable iff (rst)
        fill_req_q |-> $past(look) && $past(is_pf) && !$past(dc_hit) && $past(cacheable_attribute)
        && !$past(fill_busy))
        else $error("prefetch fill without its conditions");
    a_stall_hold: assert property (@(posedge clk) disable iff (rst)
        wb_req_q && !wb_ready |=> stall_q && wb_req_q)
        else $error("core released before write-back accepted");
    a_line_aligned: assert property (@(posedge clk) disable iff (rst)
        lookup_q |-> line_addr_q[4:0] == 5'h00)
        else $error("line address not aligned to 32 bytes");

    // write-back handshake steps: waiting for the next level, then taken
    sequence s_wb_wait;
        wb_req_q && !wb_ready;
    endsequence
    sequence s_wb_taken;
        wb_req_q && wb_ready;
    endsequence
    a_wb_release: assert property (@(posedge clk) disable iff (rst)
        s_wb_taken |=> !stall_q && !wb_req_q)
        else $error("core still stalled after write-back was taken");
    a_wb_no_finish: assert property (@(posedge clk) disable iff (rst)
        s_wb_wait |=> !ptr_wr_q && !dc_clean_q && !dc_inval_q)
        else $error("op completed before write-back was taken");
    a_wb_line_steady: assert property (@(posedge clk) disable iff (rst)
        s_wb_wait |=> $stable(line_addr_q))
        else $error("write-back address moved while pending");
    a_busy_ignored: assert property (@(posedge clk) disable iff (rst)
        insn_valid && stall_q |=> $stable(line_addr_q) && !reject_q)
        else $error("word offered while busy was not ignored");
    a_lookup_single: assert property (@(posedge clk) disable iff (rst)
        lookup_q |=> !lookup_q)
        else $error("lookup held for more than one cycle");
    a_postinc_only: assert property (@(posedge clk) disable iff (rst)
        ptr_wr_q |-> $past(postinc_q))
        else $error("pointer written without post-increment");
    a_reject_quiet: assert property (@(posedge clk) disable iff (rst)
        reject_q |-> !stall_q && !lookup_q)
        else $error("refused word started an op");
endmodule

// >>> clmo_cache_model.sv
// partner model: cache lookup answers and the next memory level
`timescale 1ns/1ns
module clmo_cache_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // requests from the unit
    input wire logic lookup_q,
    input wire logic wb_req_q,
    // setup {hit, dirty, fault, cacheable, busy} and write-back wait
    input wire logic [4:0] cfg,
    input wire logic [3:0] wb_delay,
    // answers
    output logic dc_hit,
    output logic dc_dirty,
    output logic prot_fault,
    output logic cacheable_attribute,
    output logic fill_busy,
    output logic wb_ready
);
    logic [3:0] cnt_q;
    logic tog_q;
    // answers are only meaningful in the lookup cycle; toggling elsewhere exposes stale use
    assign {dc_hit, dc_dirty, prot_fault, cacheable_attribute, fill_busy} = lookup_q ? cfg : {5{tog_q}};
    assign wb_ready = wb_req_q && (cnt_q == wb_delay);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 4'h0;
            tog_q <= 1'b0;
        end else begin
            tog_q <= ~tog_q;
            cnt_q <= (wb_req_q && !wb_ready) ? cnt_q + 4'h1 : 4'h0;
        end
    end
endmodule

// >>> test_clmo_line_ops.sv
// testbench for the cache line maintenance unit
`timescale 1ns/1ns
module test_clmo_line_ops;
    logic clk, rst, insn_valid, insn_parallel, ptr_wr_q, stall_q, reject_q, lookup_q, dc_hit, dc_dirty;
    logic prot_fault, cacheable_attribute, fill_busy, dc_clean_q, dc_inval_q, ic_inval_q, fill_req_q;
    logic wb_req_q, wb_ready;
    logic [15:0] insn_word;
    logic [31:0] ptr_value, ptr_wr_data_q, line_addr_q;
    logic [2:0] ptr_wr_idx_q;
    logic [4:0] cfg;
    logic [3:0] wb_delay;
    int n_fail, cmp_count, cycles;
    clmo_line_ops clmo_line_ops_i (.clk(clk), .rst(rst), .insn_valid(insn_valid), .insn_word(insn_word),
        .insn_parallel(insn_parallel), .ptr_value(ptr_value), .ptr_wr_q(ptr_wr_q), .ptr_wr_idx_q(ptr_wr_idx_q),
        .ptr_wr_data_q(ptr_wr_data_q), .stall_q(stall_q), .reject_q(reject_q), .lookup_q(lookup_q),
        .line_addr_q(line_addr_q), .dc_hit(dc_hit), .dc_dirty(dc_dirty), .prot_fault(prot_fault),
        .cacheable_attribute(cacheable_attribute), .fill_busy(fill_busy), .dc_clean_q(dc_clean_q),
        .dc_inval_q(dc_inval_q), .ic_inval_q(ic_inval_q), .fill_req_q(fill_req_q), .wb_req_q(wb_req_q),
        .wb_ready(wb_ready));
    clmo_cache_model clmo_cache_model_i (.clk(clk), .rst(rst), .lookup_q(lookup_q), .wb_req_q(wb_req_q),
        .cfg(cfg), .wb_delay(wb_delay), .dc_hit(dc_hit), .dc_dirty(dc_dirty), .prot_fault(prot_fault),
        .cacheable_attribute(cacheable_attribute), .fill_busy(fill_busy), .wb_ready(wb_ready));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // issue one op and judge outputs; flags are {clean, dinval, iinval, fill, wb}
    task automatic do_op(input logic [1:0] op, input logic pinc, input logic [31:0] ptr, input logic [4:0] c,
                         input logic [3:0] dly, input logic [4:0] exp);
        logic [4:0] seen;
        int wbc;
        seen = 5'h00;
        wbc = 0;
        cfg = c;
        wb_delay = dly;
        insn_word = {clmo_pkg::CC_SIGNATURE, pinc, op, 3'h5};
        ptr_value = ptr;
        insn_valid = 1'b1;
        @(negedge clk);
        insn_valid = 1'b0;
        check("lookup", lookup_q, 32'h1);
        check("line_addr", line_addr_q, ptr & clmo_pkg::LINE_MASK);
        for (int i = 0; i < 20 && stall_q === 1'b1; i++) begin
            @(negedge clk);
            seen |= {dc_clean_q, dc_inval_q, ic_inval_q, fill_req_q, wb_req_q};
            wbc += wb_req_q;
            if (wb_req_q === 1'b1) check("stall_wb", stall_q, 32'h1);
            if (ptr_wr_q === 1'b1) check("ptr_data", ptr_wr_data_q, ptr + clmo_pkg::LINE_INCR);
        end
        check("flags", seen, exp);
        check("wb_cycles", wbc, exp[0] ? dly + 1 : 0);
        check("ptr_wr", ptr_wr_q, pinc);
        check("ptr_idx", ptr_wr_idx_q, 32'h5);
    endtask
    // a second word offered in the lookup cycle of a dirty write-back must be ignored
    task automatic t_busy();
        logic seen_ii;
        seen_ii = 1'b0;
        cfg = 5'b11010;
        wb_delay = 4'h3;
        insn_word = {clmo_pkg::CC_SIGNATURE, 1'b0, 2'h1, 3'h2};
        ptr_value = 32'h0000_c000;
        insn_valid = 1'b1;
        @(negedge clk);
        insn_word = {clmo_pkg::CC_SIGNATURE, 1'b0, 2'h3, 3'h4};
        ptr_value = 32'h0000_d000;
        @(negedge clk);
        insn_valid = 1'b0;
        check("busy_no_reject", reject_q, 32'h0);
        check("busy_line", line_addr_q, 32'h0000_c000);
        for (int i = 0; i < 20 && stall_q === 1'b1; i++) begin
            @(negedge clk);
            seen_ii |= ic_inval_q;
        end
        check("busy_ignored", {seen_ii, stall_q}, 32'h0);
    endtask
    // reset in the middle of a pending write-back, then two idle edges
    task automatic t_reset();
        cfg = 5'b11010;
        wb_delay = 4'hf;
        insn_word = {clmo_pkg::CC_SIGNATURE, 1'b1, 2'h1, 3'h3};
        ptr_value = 32'h0000_e000;
        insn_valid = 1'b1;
        @(negedge clk);
        insn_valid = 1'b0;
        repeat (2) @(negedge clk);
        check("wb_pending", wb_req_q, 32'h1);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        check("rst_idle", {stall_q, wb_req_q, lookup_q, ptr_wr_q}, 32'h0);
        repeat (2) @(negedge clk);
        check("rel_idle", {stall_q, wb_req_q, reject_q, dc_clean_q, ptr_wr_q}, 32'h0);
    endtask
    task automatic t_wback();
        do_op(2'h1, 1'b1, 32'h1234_567f, 5'b11010, 4'h2, 5'b10001);
        do_op(2'h1, 1'b0, 32'h0000_0040, 5'b10010, 4'h0, 5'b00000);
        do_op(2'h1, 1'b1, 32'hffff_ffe5, 5'b01010, 4'h0, 5'b00000);
        do_op(2'h1, 1'b0, 32'h0000_0080, 5'b11110, 4'h0, 5'b00000);
    endtask
    task automatic t_wbinv();
        do_op(2'h2, 1'b1, 32'h0000_1001, 5'b11010, 4'h0, 5'b01001);
        do_op(2'h2, 1'b0, 32'h0000_2002, 5'b10010, 4'h0, 5'b01000);
        do_op(2'h2, 1'b0, 32'h0000_3003, 5'b01010, 4'h0, 5'b00000);
        do_op(2'h2, 1'b1, 32'h0000_4004, 5'b11110, 4'h0, 5'b00000);
    endtask
    task automatic t_iinv();
        do_op(2'h3, 1'b1, 32'h0000_5005, 5'b11010, 4'h0, 5'b00100);
        do_op(2'h3, 1'b0, 32'h0000_6006, 5'b00110, 4'h0, 5'b00000);
    endtask
    task automatic t_prefetch();
        do_op(2'h0, 1'b1, 32'h0000_7007, 5'b00010, 4'h0, 5'b00010);
        do_op(2'h0, 1'b0, 32'h0000_8008, 5'b00000, 4'h0, 5'b00000);
        do_op(2'h0, 1'b0, 32'h0000_9009, 5'b10010, 4'h0, 5'b00000);
        do_op(2'h0, 1'b0, 32'h0000_a00a, 5'b00011, 4'h0, 5'b00000);
        do_op(2'h0, 1'b1, 32'h0000_b00b, 5'b00110, 4'h0, 5'b00000);
    endtask
    // first pass: bundled word; second pass: word with a wrong signature
    task automatic t_reject();
        for (int k = 0; k < 2; k++) begin
            insn_word = {(k == 0) ? clmo_pkg::CC_SIGNATURE : ~clmo_pkg::CC_SIGNATURE, 1'b0, 2'h1, 3'h1};
            insn_parallel = (k == 0);
            insn_valid = 1'b1;
            @(negedge clk);
            insn_valid = 1'b0;
            insn_parallel = 1'b0;
            check("reject", reject_q, 32'h1);
            check("no_lookup", {lookup_q, stall_q}, 32'h0);
            @(negedge clk);
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles > 3000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        n_fail = 0;
        cmp_count = 0;
        cycles = 0;
        rst = 1'b1;
        insn_valid = 1'b0;
        insn_parallel = 1'b0;
        insn_word = 16'h0000;
        ptr_value = 32'h0000_0000;
        cfg = 5'h00;
        wb_delay = 4'h0;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        t_wback();
        t_wbinv();
        t_reset();
        t_iinv();
        t_prefetch();
        t_busy();
        t_reject();
        conclude();
    end
endmodule
